/* design/eep_pkg.sv */
// shared constants and state encodings for the serial eeprom front end
package eep_pkg;
  localparam int          CLK_PERIOD_NS            = 10;
  localparam int          SPIKE_FILTER_WIDTH_NS    = 50;
  localparam int          SPIKE_CYC                = (SPIKE_FILTER_WIDTH_NS + CLK_PERIOD_NS - 1)
                                                     / CLK_PERIOD_NS;
  localparam int          POWERUP_READY_DELAY_MS   = 1;
  localparam int          POWERUP_READY_CYC        = POWERUP_READY_DELAY_MS * 1000000
                                                     / CLK_PERIOD_NS;
  localparam int          INTERNAL_PROGRAM_TIME_MS = 5;
  localparam int          INTERNAL_PROGRAM_CYC     = INTERNAL_PROGRAM_TIME_MS * 1000000
                                                     / CLK_PERIOD_NS;
  localparam int          TMR_W                    = 20;
  localparam logic [3:0]  TYPE_CODE                = 4'ha;
  localparam logic [3:0]  BYTE_BITS                = 4'h8;
  localparam logic [2:0]  IDX_ADDR_LO              = 3'h2;
  localparam logic [2:0]  IDX_FIRST_DATA           = 3'h3;
  localparam logic [2:0]  IDX_SAT                  = 3'h4;
  localparam logic [3:0]  LAST_GROUP               = 4'hf;
  localparam logic [1:0]  RD_ISSUE                 = 2'h1;
  localparam logic [1:0]  RD_WAIT                  = 2'h2;
  localparam logic [1:0]  RD_TAKE                  = 2'h3;

  typedef enum logic [2:0] {B_IDLE, B_RX, B_ACK, B_TX, B_RACK} eep_bus_st_t;
  typedef enum logic [2:0] {P_IDLE, P_SCAN, P_WAITRD, P_MERGE, P_HOLD} eep_prog_st_t;
endpackage

/* design/eep_line_if.sv */
// filtered bus line: level plus one-cycle edge pulses
`timescale 1ns/1ps
`default_nettype none
interface eep_line_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, rise, fall);
  modport dst (input level, rise, fall);
endinterface
`default_nettype wire

/* design/eep_spike_filter.sv */
// pin synchroniser and spike filter for one bus line
`timescale 1ns/1ps
`default_nettype none
module eep_spike_filter (
  input  wire logic   sys_clk,  // system clock
  input  wire logic   rstn,     // async reset, active low
  input  wire logic   raw,      // asynchronous pin level
  eep_line_if.src     line      // filtered level and edges
);
  typedef struct packed {
    logic       meta;
    logic       sync;
    logic [2:0] cnt;
    logic       level;
    logic       rise;
    logic       fall;
  } eep_filt_state_t;

  eep_filt_state_t s_reg;
  eep_filt_state_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = raw;
    s_next.sync = s_reg.meta;
    s_next.rise = 1'b0;
    s_next.fall = 1'b0;
    // [R4] reject short pulses
    if (s_reg.sync == s_reg.level) begin
      s_next.cnt = 3'h0;
    end else if (s_reg.cnt == 3'(eep_pkg::SPIKE_CYC)) begin
      s_next.level = s_reg.sync;
      s_next.rise  = s_reg.sync;
      s_next.fall  = ~s_reg.sync;
      s_next.cnt   = 3'h0;
    end else begin
      s_next.cnt = s_reg.cnt + 3'h1;
    end
  end

  // idle bus lines are high, so reset to high to avoid a false edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{meta: 1'b1, sync: 1'b1, cnt: 3'h0, level: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign line.level = s_reg.level;
  assign line.rise  = s_reg.rise;
  assign line.fall  = s_reg.fall;
endmodule
`default_nettype wire

/* design/eep_front_end.sv */
// serial eeprom bus front end: slave protocol, page buffer, ecc and program timing
//
// Functional notes
// [R1] six check bits correct one error per group
// [R2] partial group write reprograms whole group
// [R3] master should write multiples of four bytes
// [R4] ignore spikes up to fifty nanoseconds
// [R5] ready for commands within one millisecond
// [R6] power-on reset drives standby and reset
// [R7] sample on rising, drive on falling, open-drain
// [R8] unconnected straps and write inhibit read low
// [R9] write inhibit high blocks all array writes
// [R10] address byte: type code, selects, direction
// [R11] master owns clock, start and stop
// [R12] transmitter pulls low for zero, releases one
// [R13] data changes while clock high mean conditions
// [R14] start is falling data while clock high
// [R15] stop starts program or returns to standby
// [R16] acknowledge matching address and write bytes
// [R17] read: release ninth clock, continue on ack
// [R18] master ends read with no-ack then stop
// [R19] master starts only on an idle bus
// [R20] word address: top ignored, page, byte
// [R21] no address acknowledge while programming
// [R22] write inhibit sampled before first data byte
// [R23] program cycle ends within five milliseconds
// [R24] mismatched address leaves data line released
`timescale 1ns/1ps
`default_nettype none
module eep_front_end #(
  parameter int POWERUP_READY_CYC    = eep_pkg::POWERUP_READY_CYC,   // power-up wait
  parameter int INTERNAL_PROGRAM_CYC = eep_pkg::INTERNAL_PROGRAM_CYC // program cycle length
) (
  input  wire logic        sys_clk,            // 100 MHz system clock
  input  wire logic        rstn,               // power-on reset, active low
  input  wire logic        scl_pin,            // serial clock pin
  input  wire logic        sda_pin_i,          // serial data pin level
  output var  logic        sda_pin_o,          // serial data drive value, always low
  output var  logic        sda_pin_oe,         // high while pulling data low
  input  wire logic        wp_pin,             // write inhibit pin
  input  wire logic        device_select_bit_0, // strap bit 0
  input  wire logic        device_select_bit_1, // strap bit 1
  input  wire logic        device_select_bit_2, // strap bit 2
  output var  logic        mem_rd_en,          // array group read strobe
  output var  logic        mem_wr_en,          // array group write strobe
  output var  logic [12:0] mem_addr,           // array group index
  output var  logic [37:0] mem_wdata,          // {check, data} to array
  input  wire logic [37:0] mem_rdata,          // {check, data} one cycle after read
  output var  logic        ready,              // power-up wait over
  output var  logic        busy,               // program cycle running
  output var  logic        ecc_fix             // pulse: a byte fetch for transmit was corrected
);
  typedef struct packed {
    eep_pkg::eep_bus_st_t      bst;
    eep_pkg::eep_prog_st_t     pst;
    logic [3:0]                bit_cnt;
    logic [2:0]                byte_idx;
    logic                      dir;
    logic                      wp_hit;
    logic [7:0]                rx;
    logic [7:0]                tx;
    logic [14:0]               addr;
    logic [63:0]               mask;
    logic [63:0][7:0]          page;
    logic [1:0]                rd_step;
    logic [3:0]                grp;
    logic [eep_pkg::TMR_W-1:0] tmr;
    logic                      ready;
    logic [3:0]                pin_meta;
    logic [3:0]                pin_sync;
    logic                      sda_oe;
    logic                      mem_rd;
    logic                      mem_wr;
    logic [12:0]               maddr;
    logic [37:0]               wdata;
    logic                      ecc_fix;
    logic                      busy;
  } eep_core_state_t;

  eep_core_state_t s_reg;
  eep_core_state_t s_next;
  eep_line_if      scl ();
  eep_line_if      sda ();

  // [R11] clock only sampled
  eep_spike_filter u_scl_filt (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .raw     (scl_pin),
    .line    (scl)
  );

  eep_spike_filter u_sda_filt (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .raw     (sda_pin_i),
    .line    (sda)
  );

  // hamming position of data bit k, skipping the power-of-two slots
  function automatic logic [5:0] eep_pos(input int k);
    logic [5:0] p;
    p = 6'(k + 1);
    for (int j = 0; j < 6; j++) begin
      if (6'(1 << j) <= p) begin
        p = p + 6'h1;
      end
    end
    return p;
  endfunction

  function automatic logic [5:0] eep_ecc_bits(input logic [31:0] d);
    logic [5:0] c;
    logic [5:0] p;
    c = 6'h0;
    for (int k = 0; k < 32; k++) begin
      p = eep_pos(k);
      for (int j = 0; j < 6; j++) begin
        c[j] = c[j] ^ (d[k] & p[j]);
      end
    end
    return c;
  endfunction

  // returns {syndrome nonzero, corrected data}
  function automatic logic [32:0] eep_ecc_fix(input logic [37:0] w);
    logic [5:0]  syn;
    logic [31:0] d;
    syn = w[37:32] ^ eep_ecc_bits(w[31:0]);
    d   = w[31:0];
    for (int k = 0; k < 32; k++) begin
      if (syn == eep_pos(k)) begin
        d[k] = ~d[k];
      end
    end
    return {syn != 6'h0, d};
  endfunction

  always_comb begin
    logic        start;
    logic        stop;
    logic        ack;
    logic [32:0] fx;
    logic [31:0] d;
    logic [5:0]  bi;
    start     = scl.level & sda.fall;
    stop      = scl.level & sda.rise;
    ack       = 1'b0;
    fx        = eep_ecc_fix(mem_rdata);
    d         = fx[31:0];
    bi        = {s_reg.grp, 2'b00};
    s_next         = s_reg;
    s_next.mem_rd  = 1'b0;
    s_next.mem_wr  = 1'b0;
    s_next.ecc_fix = 1'b0;
    // [R8] undriven pins come in low
    s_next.pin_meta = {wp_pin, device_select_bit_2, device_select_bit_1, device_select_bit_0};
    s_next.pin_sync = s_reg.pin_meta;

    // [R5] power-up wait
    if (!s_reg.ready) begin
      if (s_reg.tmr == eep_pkg::TMR_W'(POWERUP_READY_CYC - 1)) begin
        s_next.ready = 1'b1;
        s_next.tmr   = '0;
      end else begin
        s_next.tmr = s_reg.tmr + 1'b1;
      end
    end

    // byte fetch for transmit: issue, wait one cycle, take corrected byte
    unique case (s_reg.rd_step)
      eep_pkg::RD_ISSUE: begin
        s_next.mem_rd  = 1'b1;
        s_next.maddr   = s_reg.addr[14:2];
        s_next.rd_step = eep_pkg::RD_WAIT;
      end
      eep_pkg::RD_WAIT: begin
        s_next.rd_step = eep_pkg::RD_TAKE;
      end
      eep_pkg::RD_TAKE: begin
        // [R1] corrected read
        s_next.tx      = d[{s_reg.addr[1:0], 3'b000} +: 8];
        s_next.ecc_fix = fx[32];
        s_next.rd_step = 2'h0;
      end
      default: begin
      end
    endcase

    // [R23] program cycle timing
    if (s_reg.pst != eep_pkg::P_IDLE) begin
      s_next.tmr = s_reg.tmr + 1'b1;
    end
    unique case (s_reg.pst)
      eep_pkg::P_IDLE: begin
      end
      eep_pkg::P_SCAN: begin
        if (s_reg.mask[bi +: 4] != 4'h0) begin
          s_next.mem_rd = 1'b1;
          s_next.maddr  = {s_reg.addr[14:6], s_reg.grp};
          s_next.pst    = eep_pkg::P_WAITRD;
        end else if (s_reg.grp == eep_pkg::LAST_GROUP) begin
          s_next.pst = eep_pkg::P_HOLD;
        end else begin
          s_next.grp = s_reg.grp + 4'h1;
        end
      end
      eep_pkg::P_WAITRD: begin
        s_next.pst = eep_pkg::P_MERGE;
      end
      eep_pkg::P_MERGE: begin
        // [R2] read-merge-write of whole group
        for (int b = 0; b < 4; b++) begin
          if (s_reg.mask[bi + 6'(b)]) begin
            d[b*8 +: 8] = s_reg.page[bi + 6'(b)];
          end
        end
        s_next.wdata  = {eep_ecc_bits(d), d};
        s_next.mem_wr = 1'b1;
        s_next.pst    = (s_reg.grp == eep_pkg::LAST_GROUP) ? eep_pkg::P_HOLD : eep_pkg::P_SCAN;
        s_next.grp    = s_reg.grp + 4'h1;
      end
      eep_pkg::P_HOLD: begin
        if (s_reg.tmr >= eep_pkg::TMR_W'(INTERNAL_PROGRAM_CYC - 1)) begin
          s_next.pst  = eep_pkg::P_IDLE;
          s_next.mask = '0;
          s_next.tmr  = '0;
        end
      end
    endcase

    // [R13] conditions override any bit phase
    if (start && s_reg.ready) begin
      // [R14] a command begins only here
      s_next.bst      = eep_pkg::B_RX;
      s_next.bit_cnt  = 4'h0;
      s_next.byte_idx = 3'h0;
      s_next.sda_oe   = 1'b0;
    end else if (stop) begin
      // [R15] stop after write data programs
      s_next.bst    = eep_pkg::B_IDLE;
      s_next.sda_oe = 1'b0;
      if (!s_reg.dir && s_reg.mask != '0 && !s_reg.wp_hit && s_reg.pst == eep_pkg::P_IDLE) begin
        s_next.pst = eep_pkg::P_SCAN;
        s_next.grp = 4'h0;
        s_next.tmr = '0;
      end
    end else begin
      unique case (s_reg.bst)
        eep_pkg::B_IDLE: begin
        end
        eep_pkg::B_RX: begin
          if (scl.rise && s_reg.bit_cnt < eep_pkg::BYTE_BITS) begin
            // [R7] sample on rising edge
            s_next.rx      = {s_reg.rx[6:0], sda.level};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end else if (scl.fall && s_reg.bit_cnt == eep_pkg::BYTE_BITS) begin
            if (s_reg.byte_idx == 3'h0) begin
              // [R10] type code and straps
              // [R21] busy devices stay silent
              if (s_reg.rx[7:4] == eep_pkg::TYPE_CODE && s_reg.rx[3:1] == s_reg.pin_sync[2:0]
                  && s_reg.pst == eep_pkg::P_IDLE) begin
                ack        = 1'b1;
                s_next.dir = s_reg.rx[0];
                if (!s_reg.rx[0]) begin
                  s_next.mask   = '0;
                  s_next.wp_hit = 1'b0;
                end
              end
            end else if (s_reg.byte_idx == 3'h1) begin
              // [R20] top bit dropped
              s_next.addr[14:8] = s_reg.rx[6:0];
              ack               = 1'b1;
            end else if (s_reg.byte_idx == eep_pkg::IDX_ADDR_LO) begin
              s_next.addr[7:0] = s_reg.rx;
              ack              = 1'b1;
            end else if (!s_reg.wp_hit) begin
              // [R20] wrap inside the page
              s_next.page[s_reg.addr[5:0]] = s_reg.rx;
              s_next.mask[s_reg.addr[5:0]] = 1'b1;
              s_next.addr[5:0]             = s_reg.addr[5:0] + 6'h1;
              ack                          = 1'b1;
            end
            if (ack) begin
              // [R16] hold data low for ninth clock
              s_next.sda_oe   = 1'b1;
              s_next.bst      = eep_pkg::B_ACK;
              s_next.byte_idx = (s_reg.byte_idx == eep_pkg::IDX_SAT) ? s_reg.byte_idx
                                                                      : s_reg.byte_idx + 3'h1;
            end else begin
              // [R24] release and wait for start
              s_next.bst = eep_pkg::B_IDLE;
            end
          end
        end
        eep_pkg::B_ACK: begin
          if (scl.rise && s_reg.dir && s_reg.byte_idx == 3'h1) begin
            s_next.rd_step = eep_pkg::RD_ISSUE;
          end
          if (scl.fall) begin
            s_next.sda_oe = 1'b0;
            // [R22] strobe write inhibit here
            if (!s_reg.dir && s_reg.byte_idx == eep_pkg::IDX_FIRST_DATA) begin
              s_next.wp_hit = s_reg.pin_sync[3];
            end
            if (s_reg.dir) begin
              // [R12] low only for a zero
              s_next.sda_oe  = ~s_reg.tx[7];
              s_next.tx      = {s_reg.tx[6:0], 1'b1};
              s_next.bit_cnt = 4'h1;
              s_next.bst     = eep_pkg::B_TX;
            end else begin
              s_next.bit_cnt = 4'h0;
              s_next.bst     = eep_pkg::B_RX;
            end
          end
        end
        eep_pkg::B_TX: begin
          if (scl.fall) begin
            // [R7] drive on falling edge
            if (s_reg.bit_cnt == eep_pkg::BYTE_BITS) begin
              // [R17] released for ninth clock
              s_next.sda_oe = 1'b0;
              s_next.bst    = eep_pkg::B_RACK;
            end else begin
              s_next.sda_oe  = ~s_reg.tx[7];
              s_next.tx      = {s_reg.tx[6:0], 1'b1};
              s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            end
          end
        end
        eep_pkg::B_RACK: begin
          if (scl.rise) begin
            s_next.addr = s_reg.addr + 15'h1;
            if (!sda.level) begin
              // [R17] master ack: fetch next byte
              s_next.rd_step = eep_pkg::RD_ISSUE;
              s_next.bst     = eep_pkg::B_ACK;
            end else begin
              // [R18] no-ack ends the read
              s_next.bst = eep_pkg::B_IDLE;
            end
          end
        end
        default: begin
          s_next.bst = eep_pkg::B_IDLE;
        end
      endcase
    end
    s_next.busy = s_next.pst != eep_pkg::P_IDLE;
  end

  // [R6] power-on reset puts everything in standby
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg     <= '0;
      s_reg.bst <= eep_pkg::B_IDLE;
      s_reg.pst <= eep_pkg::P_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs other than sda_pin_o are registered state fields; the data pin can only pull low
  assign sda_pin_o  = 1'b0;
  assign sda_pin_oe = s_reg.sda_oe;
  assign mem_rd_en  = s_reg.mem_rd;
  // [R9] writes only after inhibit check
  assign mem_wr_en  = s_reg.mem_wr;
  assign mem_addr   = s_reg.maddr;
  assign mem_wdata  = s_reg.wdata;
  assign ready      = s_reg.ready;
  assign busy       = s_reg.busy;
  assign ecc_fix    = s_reg.ecc_fix;
endmodule
`default_nettype wire

/* verif/eep_props.sv */
// concurrent checks on the serial eeprom front end ports
`timescale 1ns/1ps
`default_nettype none
module eep_props #(
  parameter int POWERUP_READY_CYC    = 100000, // power-up wait
  parameter int INTERNAL_PROGRAM_CYC = 500000  // program cycle length
) (
  input wire logic        sys_clk,    // system clock
  input wire logic        rstn,       // async reset, active low
  input wire logic        scl_pin,    // serial clock pin
  input wire logic        sda_pin_o,  // data drive value
  input wire logic        sda_pin_oe, // data pull enable
  input wire logic        mem_rd_en,  // group read strobe
  input wire logic        mem_wr_en,  // group write strobe
  input wire logic [12:0] mem_addr,   // group index
  input wire logic        ready,      // power-up wait over
  input wire logic        busy,       // program cycle running
  input wire logic        ecc_fix     // corrected read pulse
);
  int up_cnt;
  int busy_cnt;

  // saturating so the late-ready check keeps holding after power-up
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_cnt   <= 0;
      busy_cnt <= 0;
    end else begin
      if (up_cnt < POWERUP_READY_CYC + 8) up_cnt <= up_cnt + 1;
      busy_cnt <= busy ? busy_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  open_drain_a: assert property (sda_pin_o == 1'b0)
    else $error("data drive value not low");
  quiet_unready_a: assert property (!ready |-> !sda_pin_oe)
    else $error("data driven before ready");
  ready_early_a: assert property (ready |-> up_cnt >= POWERUP_READY_CYC)
    else $error("ready too early");
  ready_late_a: assert property (up_cnt >= POWERUP_READY_CYC + 4 |-> ready)
    else $error("ready too late");
  busy_quiet_a: assert property (busy |-> !sda_pin_oe)
    else $error("data driven while programming");
  group_rewrite_a: assert property (mem_wr_en |->
    $past(mem_rd_en, 2) && mem_addr == $past(mem_addr, 2))
    else $error("group write without its read");
  write_in_cycle_a: assert property (mem_wr_en |-> busy)
    else $error("array write outside program cycle");
  busy_max_a: assert property (busy_cnt <= INTERNAL_PROGRAM_CYC + 1)
    else $error("program cycle too long");
  busy_len_a: assert property ($fell(busy) |-> busy_cnt >= INTERNAL_PROGRAM_CYC - 4)
    else $error("program cycle too short");
  drive_scl_low_a: assert property ($changed(sda_pin_oe) |-> !scl_pin)
    else $error("data drive changed while clock high");
  fix_pulse_a: assert property (ecc_fix |=> !ecc_fix)
    else $error("correction flag longer than a pulse");
endmodule
`default_nettype wire

/* verif/eep_master.sv */
// bus master model: owns the serial clock, conditions and its data bits
`timescale 1ns/1ps
`default_nettype none
module eep_master #(
  parameter int T_HALF = 500 // clock half period in ns
) (
  output var logic scl,     // serial clock, stands high when idle
  output var logic sda_low, // high while the master pulls data low
  input  wire logic sda_wire // resolved data line
);
  localparam int TQ = T_HALF / 2;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #TQ sda_low = 1'b0;
    #TQ scl = 1'b1;
    #T_HALF sda_low = 1'b1;
    #T_HALF scl = 1'b0;
  endtask

  task automatic stop();
    #TQ sda_low = 1'b1;
    #TQ scl = 1'b1;
    #T_HALF sda_low = 1'b0;
    #T_HALF;
  endtask

  // data moves only while clock low
  task automatic bit_io(input logic b, output logic r);
    #TQ sda_low = ~b;
    #TQ scl = 1'b1;
    #TQ r = sda_wire;
    #TQ scl = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // no acknowledge on the last byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // short clock glitch inside a low phase, well clear of the falling edge
  task automatic spike_scl(input int ns);
    #TQ scl = 1'b1;
    #(ns) scl = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/eep_front_end_tb.sv */
// self-checking bench for the serial eeprom bus front end
`timescale 1ns/1ps
`default_nettype none
module eep_front_end_tb;
  localparam int PRC = 20;
  localparam int IPC = 1500;
  localparam int LIMIT = 60000;
  localparam logic [7:0] BAD [5] = '{8'hea, 8'hba, 8'ha2, 8'hae, 8'ha8};
  logic        sys_clk = 1'b0;
  logic        rstn, scl, sda_low, sda_wire, wp_pin, sda_pin_o, sda_pin_oe;
  logic        mem_rd_en, mem_wr_en, ready, busy, ecc_fix, ack;
  logic [2:0]  ds;
  logic [12:0] mem_addr;
  logic [37:0] mem_wdata;
  logic [37:0] mem_rdata = 38'h0;
  logic [7:0]  d0, d1;
  logic [37:0] mem [int];
  int          fails, checks_done, wr_cnt, fix_cnt, cyc, n;

  always #5 sys_clk = ~sys_clk;
  // open drain with pull-up: anyone pulling wins
  assign sda_wire = ~(sda_low | (sda_pin_oe & ~sda_pin_o));

  eep_front_end #(.POWERUP_READY_CYC(PRC), .INTERNAL_PROGRAM_CYC(IPC)) i_eep_front_end (
    .sys_clk(sys_clk), .rstn(rstn), .scl_pin(scl), .sda_pin_i(sda_wire),
    .sda_pin_o(sda_pin_o), .sda_pin_oe(sda_pin_oe), .wp_pin(wp_pin),
    .device_select_bit_0(ds[0]), .device_select_bit_1(ds[1]),
    .device_select_bit_2(ds[2]), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .ready(ready), .busy(busy), .ecc_fix(ecc_fix));
  eep_master #(.T_HALF(500)) i_eep_master (.scl(scl), .sda_low(sda_low), .sda_wire(sda_wire));

  // registered array: absent groups read as zero, a valid codeword
  always @(posedge sys_clk) begin
    if (mem_rd_en === 1'b1)
      mem_rdata <= mem.exists(int'(mem_addr)) ? mem[int'(mem_addr)] : 38'h0;
    if (mem_wr_en === 1'b1) begin
      mem[int'(mem_addr)] = mem_wdata;
      wr_cnt++;
    end
    if (ecc_fix === 1'b1) fix_cnt++;
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      $display("Error %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic chk(input logic [37:0] got, input logic [37:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic addr_phase(input logic [15:0] a);
    logic a1, a2, a3;
    i_eep_master.start();
    i_eep_master.wr_byte(8'haa, a1);
    i_eep_master.wr_byte(a[15:8], a2);
    i_eep_master.wr_byte(a[7:0], a3);
    ack = a1 & a2 & a3;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    wp_pin = 1'b0;
    ds = 3'h5;
    {fails, checks_done, wr_cnt, fix_cnt, cyc} = '0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    for (int i = 0; i < PRC + 20 && ready !== 1'b1; i++) @(negedge sys_clk);
    chk(ready, 1'b1, "ready after power-up");
    $display("test power-up done");

    foreach (BAD[i]) begin
      i_eep_master.start();
      i_eep_master.wr_byte(BAD[i], ack);
      i_eep_master.stop();
      chk(ack, 1'b0, "foreign address acked");
    end
    // a matching address byte after a refused one, with no start between
    i_eep_master.start();
    i_eep_master.wr_byte(8'ha2, ack);
    i_eep_master.wr_byte(8'haa, ack);
    i_eep_master.stop();
    chk(ack, 1'b0, "address without start acked");
    $display("test address mismatch done");

    // top address bit set on purpose: it must be ignored
    addr_phase(16'h9235);
    chk(ack, 1'b1, "address bytes ack");
    i_eep_master.spike_scl(40);
    i_eep_master.wr_byte(8'h5a, ack);
    chk(ack, 1'b1, "first data ack");
    i_eep_master.wr_byte(8'hc3, ack);
    n = wr_cnt;
    i_eep_master.stop();
    @(negedge sys_clk);
    chk(busy, 1'b1, "program cycle after stop");
    chk(38'(wr_cnt - n), 38'h1, "groups written");
    chk({6'h0, mem['h48d][31:0]}, 38'h00c35a00, "merged group");
    $display("test partial write done");

    i_eep_master.start();
    i_eep_master.wr_byte(8'haa, ack);
    i_eep_master.stop();
    chk(ack, 1'b0, "acked while programming");
    for (int i = 0; i < IPC && busy !== 1'b0; i++) @(negedge sys_clk);
    chk(busy, 1'b0, "program cycle end");
    i_eep_master.start();
    i_eep_master.wr_byte(8'haa, ack);
    i_eep_master.stop();
    chk(ack, 1'b1, "ack after program cycle");
    chk(busy, 1'b0, "stop without data");
    $display("test polling done");

    // one stored bit flipped behind the device's back
    mem['h48d][9] = ~mem['h48d][9];
    addr_phase(16'h1235);
    i_eep_master.start();
    i_eep_master.wr_byte(8'hab, ack);
    chk(ack, 1'b1, "read address ack");
    i_eep_master.rd_byte(1'b0, d0);
    i_eep_master.rd_byte(1'b1, d1);
    i_eep_master.stop();
    chk(d0, 8'h5a, "corrected byte");
    chk(d1, 8'hc3, "next byte");
    chk(38'(fix_cnt != 0), 38'h1, "correction flagged");
    chk(busy, 1'b0, "stop after read");
    $display("test corrected read done");

    @(negedge sys_clk) wp_pin = 1'b1;
    n = wr_cnt;
    addr_phase(16'h1238);
    chk(ack, 1'b1, "protected address ack");
    i_eep_master.wr_byte(8'h11, ack);
    i_eep_master.stop();
    chk(ack, 1'b0, "protected data ack");
    chk(busy, 1'b0, "protected program cycle");
    chk(38'(wr_cnt - n), 38'h0, "protected array writes");
    @(negedge sys_clk) wp_pin = 1'b0;
    $display("test write inhibit done");

    // supply dip: back to reset, then a fresh power-up wait
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(38'({ready, busy, sda_pin_oe}), 38'h0, "outputs held in reset");
    rstn = 1'b1;
    @(negedge sys_clk);
    chk(ready, 1'b0, "ready right after reset");
    for (int i = 0; i < PRC + 20 && ready !== 1'b1; i++) @(negedge sys_clk);
    i_eep_master.start();
    i_eep_master.wr_byte(8'haa, ack);
    i_eep_master.stop();
    chk(ack, 1'b1, "ack after reset");
    $display("test supply dip done");
    final_report();
  end
endmodule

bind eep_front_end eep_props #(
  .POWERUP_READY_CYC(POWERUP_READY_CYC),
  .INTERNAL_PROGRAM_CYC(INTERNAL_PROGRAM_CYC)
) i_eep_props (
  .sys_clk(sys_clk), .rstn(rstn), .scl_pin(scl_pin), .sda_pin_o(sda_pin_o),
  .sda_pin_oe(sda_pin_oe), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
  .mem_addr(mem_addr), .ready(ready), .busy(busy), .ecc_fix(ecc_fix));
`default_nettype wire
